// >>> sacr_pkg.sv
// Purpose: Shared constants and types for the SAR converter cycle sequencer link
// Assumes: One 10 MHz clock for both ends; all link signals synchronous to it
// Notes:   Long waits are reduced to cycle counts here; the settle wait is a parameter
package sacr_pkg;
    // ----------------------------------------------------------------
    // Widths and timing
    // ----------------------------------------------------------------
    localparam int          DataWidth     = 16;
    localparam int          FifoDepth     = 8;
    localparam int          ClockHz       = 10_000_000;
    localparam int          ConvMaxNs     = 4700;
    // Longest time rounds down
    localparam int          ConvMaxCycles = (ConvMaxNs * (ClockHz / 1_000_000)) / 1000;
    // Conversion takes a little under the ceiling
    localparam int          ConvCycles    = ConvMaxCycles - 2;
    localparam int          SettleMs      = 12;
    localparam int          SettleCycles  = SettleMs * (ClockHz / 1000);
    localparam int          AcqCycles     = 20;
    localparam int          OutDelay      = 1;
    localparam logic [15:0] MidScale      = 16'h8000;
    localparam logic [15:0] ResetResult   = 16'h0000;

    // ----------------------------------------------------------------
    // Device and host states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        DEV_IDLE, DEV_ACQUIRE, DEV_CONVERT, DEV_WAIT_READ, DEV_DRIVE
    } sacr_dev_state_type;

    typedef enum logic [2:0] {
        HST_IDLE, HST_WAKE, HST_ACQUIRE, HST_CONVERT, HST_READ, HST_FINISH
    } sacr_hst_state_type;
endpackage

// >>> sacr_link_if.sv
// Purpose: Parallel link between host and converter sequencer
// Assumes: Result bus level resolved from the device output enable
// Notes:   No clocking block; both ends sample on the common clock
`timescale 1ns/1ps
`default_nettype none
interface sacr_link_if;
    logic        convStart_n;  // Active-low convert-start strobe
    logic        readSelect;   // High selects read, low selects convert
    logic        reset;        // Active-high device reset
    logic        eoc_n;        // Low once a result is valid
    logic [15:0] resultOut;
    logic        resultOe;
    logic [15:0] resultBus;

    // Resolved bus: undriven bus reads as zero in this model
    assign resultBus = resultOe ? resultOut : 16'h0000;

    modport device (input convStart_n, input readSelect, input reset,
                    output eoc_n, output resultOut, output resultOe);
    modport host   (output convStart_n, output readSelect, output reset,
                    input eoc_n, input resultBus);
endinterface
`default_nettype wire

// >>> sacr_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   Depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module sacr_fifo #(
    parameter int Width = 16,
    parameter int Depth = 8
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [Width-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [Width-1:0] outData
);
    localparam int AW = $clog2(Depth);

    typedef struct packed {
        logic [AW:0] wrPtr;
        logic [AW:0] rdPtr;
    } sacr_fifo_state_type;

    sacr_fifo_state_type state, next_state;
    logic [Width-1:0]    mem [Depth];
    logic                doWrite;
    logic                doRead;

    // ----------------------------------------------------------------
    // Flags
    // ----------------------------------------------------------------
    assign inReady  = (state.wrPtr ^ state.rdPtr) != {1'b1, {AW{1'b0}}};
    assign outValid = state.wrPtr != state.rdPtr;
    assign doWrite  = inValid && inReady;
    assign doRead   = outValid && outReady;
    assign outData  = mem[state.rdPtr[AW-1:0]];

    // Pointer update
    always_comb begin
        next_state = state;
        if (doWrite) begin
            next_state.wrPtr = state.wrPtr + 1'b1;
        end
        if (doRead) begin
            next_state.rdPtr = state.rdPtr + 1'b1;
        end
    end

    // Storage has no reset; pointers define what is valid
    always_ff @(posedge clock) begin
        if (doWrite) begin
            mem[state.wrPtr[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule
`default_nettype wire

// >>> sacr_device.sv
// Purpose: Converter-side cycle sequencer: acquire, convert, power state, readout
// Assumes: Strobe and select synchronous to clock; raw sample supplied by the user side
// Notes:   Reference power is an output level; samples queue in a FIFO before conversion
// Overview of operation
// RULE_01: Select at convert edge picks low-power state
// RULE_02: Select low: standby, reference stays powered
// RULE_03: Select high: shutdown, reference powered down
// RULE_04: From standby, strobe with select low acquires
// RULE_05: From shutdown, strobe with select low wakes
// RULE_06: Host waits 12ms settle after shutdown wake
// RULE_07: End-of-conversion flag low marks valid result
// RULE_08: Result bus undriven during acquire and convert
// RULE_09: Third strobe, select high, drives result
// RULE_10: Strobe high releases result bus
// RULE_11: After read, idle until next strobe edge
// RULE_12: Offset or straight binary coding, build option
// RULE_13: Host switches channel right after acquisition; this host drives no channel select
// RULE_14: Host lengthens acquisition or keeps standby
// RULE_15: First strobe select low acquires; high ignored
// RULE_16: Second strobe holds sample, starts conversion
// RULE_17: Convert edge to flag low within 4.7us
// RULE_18: Reset high returns device to idle
// RULE_19: Flag returns high when acquisition begins
`timescale 1ns/1ps
`default_nettype none
module sacr_device #(
    parameter bit Bipolar = 1'b1
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,

    // Link to host
    sacr_link_if.device      link,

    // Sample source: signed for bipolar, unsigned for unipolar
    input  wire logic        sampleValid,
    output logic             sampleReady,
    input  wire logic [15:0] sampleData,

    // Power status
    output logic             referenceOn,
    output logic             tracking
);
    typedef struct packed {
        // Cycle control
        sacr_pkg::sacr_dev_state_type fsm;
        logic                         strobeLast;
        logic                         shutdownSel;

        // Power and flag
        logic                         refOn;
        logic                         eocN;

        // Data path
        logic [15:0]                  result;
        logic [15:0]                  heldSample;
        logic                         oe;
        logic [12:0]                  count;
    } sacr_dev_reg_type;

    sacr_dev_reg_type state, next_state;

    // Edge and queue wires
    logic             fall;
    logic             fifoValid;
    logic             fifoReady;
    logic [15:0]      fifoData;

    // ----------------------------------------------------------------
    // Sample queue: the sample source stalls when the held samples back up
    // ----------------------------------------------------------------
    sacr_fifo #(.Width(sacr_pkg::DataWidth), .Depth(sacr_pkg::FifoDepth)) u_sacr_fifo (
        .clock    (clock),
        .rst      (rst),
        .inValid  (sampleValid),
        .inReady  (sampleReady),
        .inData   (sampleData),
        .outValid (fifoValid),
        .outReady (fifoReady),
        .outData  (fifoData)
    );

    // Coding of the held sample
    function automatic logic [15:0] codeResult(input logic [15:0] raw);
        if (Bipolar) begin
            // Offset binary
            codeResult = raw ^ sacr_pkg::MidScale; // [RULE_12]
        end else begin
            // Straight binary
            codeResult = raw;
        end
    endfunction

    // Edge against last cycle's strobe level
    assign fall = state.strobeLast && !link.convStart_n;

    // Pop one sample per conversion start; stale queued samples are the trade-off
    assign fifoReady = (state.fsm == sacr_pkg::DEV_ACQUIRE) && fall;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Edges in the wrong state or with the wrong select are dropped silently
    always_comb begin
        // Hold by default
        next_state            = state;
        next_state.strobeLast = link.convStart_n;

        unique case (state.fsm)
            // First edge
            sacr_pkg::DEV_IDLE: begin
                // Select high on the first edge is ignored
                if (fall && !link.readSelect) begin // [RULE_15] [RULE_11] [RULE_04]
                    next_state.fsm   = sacr_pkg::DEV_ACQUIRE;
                    next_state.refOn = 1'b1; // [RULE_05]
                    // New cycle, flag clears
                    next_state.eocN  = 1'b1; // [RULE_19]
                end
            end

            // Tracking
            sacr_pkg::DEV_ACQUIRE: begin
                if (fall) begin // [RULE_16]
                    next_state.fsm         = sacr_pkg::DEV_CONVERT;
                    next_state.shutdownSel = link.readSelect; // [RULE_01]
                    // Empty queue converts zero
                    next_state.heldSample  = fifoValid ? fifoData : sacr_pkg::ResetResult;
                    next_state.count       = 13'(sacr_pkg::ConvCycles);
                end
            end

            // Converting
            sacr_pkg::DEV_CONVERT: begin
                if (state.count <= 13'h0001) begin // [RULE_17]
                    next_state.fsm    = sacr_pkg::DEV_WAIT_READ;
                    // Code fixed at conversion end
                    next_state.result = codeResult(state.heldSample);
                    next_state.eocN   = 1'b0; // [RULE_07]
                    // Shutdown drops the reference; standby keeps it
                    next_state.refOn  = !state.shutdownSel; // [RULE_02] [RULE_03]
                end else begin
                    // Still converting
                    next_state.count = state.count - 13'h0001;
                end
            end

            // Result ready
            sacr_pkg::DEV_WAIT_READ: begin
                if (fall && link.readSelect) begin // [RULE_09]
                    next_state.fsm   = sacr_pkg::DEV_DRIVE;
                    next_state.count = 13'(sacr_pkg::OutDelay);
                end
            end

            // Readout
            sacr_pkg::DEV_DRIVE: begin
                // Output delay first
                if (state.count != 13'h0000) begin
                    next_state.count = state.count - 13'h0001;
                end else begin
                    next_state.oe = 1'b1;
                end

                // Strobe high ends the read
                if (link.convStart_n) begin // [RULE_10]
                    next_state.oe  = 1'b0;
                    next_state.fsm = sacr_pkg::DEV_IDLE; // [RULE_11]
                end
            end

            // Recovery
            default: begin
                next_state.fsm = sacr_pkg::DEV_IDLE;
            end
        endcase
    end

    // Reset returns to idle with flag high and bus released
    always_ff @(posedge clock) begin
        if (rst || link.reset) begin // [RULE_18]
            // Clear, then set idle levels
            state            <= '0;
            state.fsm        <= sacr_pkg::DEV_IDLE;
            // Strobe seen high: no false edge
            state.strobeLast <= 1'b1;
            state.eocN       <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Registered flag and data
    assign link.eoc_n     = state.eocN;
    assign link.resultOut = state.result;

    // Registered enable: no glitch on the bus
    assign link.resultOe  = state.oe; // [RULE_08]

    // Power status
    assign referenceOn    = state.refOn;
    assign tracking       = state.fsm == sacr_pkg::DEV_ACQUIRE;
endmodule
`default_nettype wire

// >>> sacr_host.sv
// Purpose: Host end: runs one acquire/convert/read cycle per request
// Assumes: Link synchronous to clock
// Notes:   Results queue in a FIFO; a stalled reader holds off new cycles
`timescale 1ns/1ps
`default_nettype none
module sacr_host #(
    parameter int SettleCycles = sacr_pkg::SettleCycles
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Link to device
    sacr_link_if.host        link,
    // Request
    input  wire logic        startReq,
    input  wire logic        shutdownAfter,
    input  wire logic        resetReq,
    output logic             busy,
    // Result stream
    output logic             resultValid,
    input  wire logic        resultReady,
    output logic      [15:0] resultData
);
    typedef struct packed {
        sacr_pkg::sacr_hst_state_type fsm;
        logic                         strobeN;
        logic                         sel;
        logic                         devReset;
        logic                         wasShutdown;
        logic                         modeShutdown;
        logic                         push;
        logic [15:0]                  data;
        logic [23:0]                  count;
    } sacr_hst_reg_type;

    sacr_hst_reg_type state, next_state;
    logic             fifoReady;

    // ----------------------------------------------------------------
    // Result queue
    // ----------------------------------------------------------------
    sacr_fifo #(.Width(sacr_pkg::DataWidth), .Depth(sacr_pkg::FifoDepth)) u_sacr_fifo (
        .clock    (clock),
        .rst      (rst),
        .inValid  (state.push),
        .inReady  (fifoReady),
        .inData   (state.data),
        .outValid (resultValid),
        .outReady (resultReady),
        .outData  (resultData)
    );

    always_comb begin
        next_state          = state;
        next_state.push     = 1'b0;
        next_state.devReset = 1'b0;
        unique case (state.fsm)
            sacr_pkg::HST_IDLE: begin
                next_state.strobeN = 1'b1;
                if (resetReq) begin
                    next_state.devReset    = 1'b1; // Strobe held high meanwhile
                    next_state.wasShutdown = 1'b1;
                end else if (startReq && fifoReady) begin
                    next_state.fsm     = sacr_pkg::HST_WAKE;
                    next_state.sel     = 1'b0;
                    next_state.strobeN = 1'b0;
                    next_state.modeShutdown = shutdownAfter;
                    next_state.count   = state.wasShutdown ? 24'(SettleCycles)
                                                           : 24'(sacr_pkg::AcqCycles);
                end
            end
            sacr_pkg::HST_WAKE: begin
                next_state.strobeN = 1'b1;
                next_state.fsm     = sacr_pkg::HST_ACQUIRE;
            end
            sacr_pkg::HST_ACQUIRE: begin
                // Settle wait after shutdown, or plain acquisition time
                if (state.count != 24'h000000) begin // [RULE_06] [RULE_14]
                    next_state.count = state.count - 24'h000001;
                end else begin
                    next_state.strobeN = 1'b0;
                    next_state.sel     = state.modeShutdown; // [RULE_01]
                    next_state.fsm     = sacr_pkg::HST_CONVERT;
                    next_state.wasShutdown = state.modeShutdown;
                end
            end
            sacr_pkg::HST_CONVERT: begin
                next_state.strobeN = 1'b1;
                next_state.sel     = 1'b1;
                if (!link.eoc_n && state.strobeN) begin // [RULE_07]
                    next_state.strobeN = 1'b0; // [RULE_09]
                    next_state.fsm     = sacr_pkg::HST_READ;
                    // Enable shows two edges after the device takes the edge
                    next_state.count   = 24'(sacr_pkg::OutDelay + 2);
                end
            end
            sacr_pkg::HST_READ: begin
                if (state.count != 24'h000000) begin
                    next_state.count = state.count - 24'h000001;
                end else begin
                    next_state.data    = link.resultBus;
                    next_state.push    = 1'b1;
                    next_state.strobeN = 1'b1; // [RULE_10]
                    next_state.fsm     = sacr_pkg::HST_FINISH;
                end
            end
            sacr_pkg::HST_FINISH: begin
                next_state.sel = 1'b0;
                next_state.fsm = sacr_pkg::HST_IDLE;
            end
            default: begin
                next_state.fsm = sacr_pkg::HST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state             <= '0;
            state.fsm         <= sacr_pkg::HST_IDLE;
            state.strobeN     <= 1'b1;
            state.wasShutdown <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign link.convStart_n = state.strobeN;
    assign link.readSelect  = state.sel;
    assign link.reset       = state.devReset; // [RULE_18]
    assign busy             = state.fsm != sacr_pkg::HST_IDLE;
endmodule
`default_nettype wire

// >>> sacr_link_properties.sv
// Purpose: Timing checks on the link between host and converter sequencer
// Assumes: One clock for both ends; synchronous active-high reset
// Notes:   Tracks the cycle phase from strobe falls to know which edge is which
`timescale 1ns/1ps
`default_nettype none
module sacr_link_properties (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // Link signals
    input wire logic        convStart_n,
    input wire logic        readSelect,
    input wire logic        reset,
    input wire logic        eoc_n,
    input wire logic [15:0] resultOut,
    input wire logic        resultOe,
    input wire logic [15:0] resultBus,
    // Device power status
    input wire logic        referenceOn,
    input wire logic        tracking
);
    // ----------------------------------------------------------------
    // Phase tracking: 0 idle or readout, 1 acquiring, 2 converting
    // ----------------------------------------------------------------
    logic [1:0] phase;
    logic       shut;
    logic       prevCs;
    logic       csFall;

    assign csFall = prevCs & ~convStart_n;

    // Link reset counts too, or the phase would drift after a device reset
    always_ff @(posedge clock) begin
        prevCs <= convStart_n;
        if (rst || reset) begin
            phase <= 2'h0;
        end else if (csFall && phase == 2'h0 && !readSelect) begin
            phase <= 2'h1;
        end else if (csFall && phase == 2'h1) begin
            phase <= 2'h2;
            shut  <= readSelect;
        end else if (phase == 2'h2 && !eoc_n) begin
            phase <= 2'h0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    bus_quiet_a: assert property (resultOe |-> !eoc_n && phase == 2'h0)
        else $error("Result bus driven outside readout");
    read_drive_a: assert property ($fell(convStart_n) && readSelect && !eoc_n
        && phase == 2'h0 |-> ##[2:3] resultOe)
        else $error("Result not driven after read strobe");
    bus_release_a: assert property (resultOe && convStart_n |-> ##[1:2] !resultOe)
        else $error("Result bus held after strobe high");
    data_steady_a: assert property (resultOe && $past(resultOe) |-> $stable(resultOut))
        else $error("Result changed while driven");
    conv_time_a: assert property ($fell(convStart_n) && phase == 2'h1
        |-> ##[2:47] $fell(eoc_n))
        else $error("Conversion end flag late");
    acq_start_a: assert property ($fell(convStart_n) && !readSelect && phase == 2'h0
        |-> ##3 (tracking && eoc_n))
        else $error("Acquisition did not start");
    conv_hold_a: assert property ($fell(convStart_n) && phase == 2'h1 |-> ##3 !tracking)
        else $error("Tracking not ended at convert edge");
    ref_standby_a: assert property ($fell(eoc_n) && !shut |-> referenceOn [*4])
        else $error("Reference dropped in standby");
    ref_shutdown_a: assert property ($fell(eoc_n) && shut |-> ##[0:2] !referenceOn)
        else $error("Reference kept on in shutdown");
    reset_idle_a: assert property (reset |-> ##2 (eoc_n && !resultOe && !tracking))
        else $error("Device not idle after link reset");
endmodule
`default_nettype wire

// >>> sacr_tb.sv
// Purpose: Self-checking bench for host and converter sequencer back to back
// Assumes: Settle wait shortened to 30 cycles; bipolar and unipolar builds in lockstep
// Notes:   Inputs change on the falling clock edge only
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clock;
    logic        rst;
    logic        sampleValid;
    logic        sampleReady;
    logic [15:0] sampleData;
    logic        referenceOn;
    logic        tracking;
    logic        startReq;
    logic        shutdownAfter;
    logic        resetReq;
    logic        busy;
    logic        resultValid;
    logic        resultReady;
    logic [15:0] resultData;
    logic [15:0] uniData;
    int          n_fail;
    int          n_tests;
    int          cycles;

    sacr_link_if u_sacr_link_if ();
    sacr_device #(.Bipolar(1'b1)) u_sacr_device (.clock(clock), .rst(rst),
        .link(u_sacr_link_if), .sampleValid(sampleValid), .sampleReady(sampleReady),
        .sampleData(sampleData), .referenceOn(referenceOn), .tracking(tracking));
    sacr_host #(.SettleCycles(30)) u_sacr_host (.clock(clock), .rst(rst),
        .link(u_sacr_link_if), .startReq(startReq), .shutdownAfter(shutdownAfter),
        .resetReq(resetReq), .busy(busy), .resultValid(resultValid),
        .resultReady(resultReady), .resultData(resultData));
    // Unipolar build on the same stimulus
    sacr_link_if u_sacr_link_if_uni ();
    sacr_device #(.Bipolar(1'b0)) u_sacr_device_uni (.clock(clock), .rst(rst),
        .link(u_sacr_link_if_uni), .sampleValid(sampleValid), .sampleReady(),
        .sampleData(sampleData), .referenceOn(), .tracking());
    sacr_host #(.SettleCycles(30)) u_sacr_host_uni (.clock(clock), .rst(rst),
        .link(u_sacr_link_if_uni), .startReq(startReq), .shutdownAfter(shutdownAfter),
        .resetReq(resetReq), .busy(), .resultValid(), .resultReady(resultReady),
        .resultData(uniData));
    sacr_link_properties u_sacr_link_properties (.clock(clock), .rst(rst),
        .convStart_n(u_sacr_link_if.convStart_n), .readSelect(u_sacr_link_if.readSelect),
        .reset(u_sacr_link_if.reset), .eoc_n(u_sacr_link_if.eoc_n),
        .resultOut(u_sacr_link_if.resultOut), .resultOe(u_sacr_link_if.resultOe),
        .resultBus(u_sacr_link_if.resultBus), .referenceOn(referenceOn), .tracking(tracking));

    // 10 MHz clock
    always #50 clock = ~clock;

    // Hang guard: whole run needs just over a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Offer a sample and hold it until the converter FIFO takes it
    task automatic push(input logic [15:0] s);
        sampleData  = s;
        sampleValid = 1'b1;
        for (int k = 0; k < 200 && sampleReady !== 1'b1; k++) @(negedge clock);
        @(negedge clock);
        sampleValid = 1'b0;
    endtask

    // One full acquire, convert, read cycle; returns at once if refused
    task automatic run(input logic shut);
        shutdownAfter = shut;
        startReq      = 1'b1;
        @(negedge clock);
        startReq = 1'b0;
        for (int k = 0; k < 400 && busy !== 1'b0; k++) @(negedge clock);
        @(negedge clock);
    endtask

    task automatic pop(input logic [15:0] exp);
        for (int k = 0; k < 50 && resultValid !== 1'b1; k++) @(negedge clock);
        check("resultValid", 16'(resultValid), 16'h0001);
        check("result", resultData, exp);
        check("resultUni", uniData, exp ^ sacr_pkg::MidScale);
        resultReady = 1'b1;
        @(negedge clock);
        resultReady = 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Shutdown, wake to standby, standby again, then shutdown; edge codes
    task automatic t_modes();
        logic [15:0] s [4] = '{16'h0000, 16'h7FFF, 16'h8000, 16'hFFFF};
        logic        m [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 4; i++) begin
            push(s[i]); // Next input offered once the last result was popped
            run(m[i]);
            check("refOn", 16'(referenceOn), 16'(!m[i]));
            check("eoc", 16'(u_sacr_link_if.eoc_n), 16'h0000);
            check("oe", 16'(u_sacr_link_if.resultOe), 16'h0000);
            pop(s[i] ^ sacr_pkg::MidScale);
        end
    endtask

    // Fill both FIFOs while the reader stalls, then drain in order
    task automatic t_fifo();
        for (int i = 0; i < 8; i++) push(16'h1111 * i[15:0]);
        sampleData  = 16'hABCD;
        sampleValid = 1'b1;
        @(negedge clock);
        check("sampleReady", 16'(sampleReady), 16'h0000);
        sampleValid = 1'b0;
        for (int i = 0; i < 8; i++) run(1'b0);
        startReq = 1'b1;
        @(negedge clock);
        @(negedge clock);
        check("busyFull", 16'(busy), 16'h0000);
        startReq = 1'b0;
        for (int i = 0; i < 8; i++) pop(16'h1111 * i[15:0] ^ sacr_pkg::MidScale);
    endtask

    // Link reset from idle, then a system reset in mid-conversion
    task automatic t_reset();
        resetReq = 1'b1;
        @(negedge clock);
        resetReq = 1'b0;
        for (int k = 0; k < 10 && u_sacr_link_if.eoc_n !== 1'b1; k++) @(negedge clock);
        check("eocReset", 16'(u_sacr_link_if.eoc_n), 16'h0001);
        check("refReset", 16'(referenceOn), 16'h0000);
        push(16'h1234);
        startReq = 1'b1;
        @(negedge clock);
        startReq = 1'b0;
        repeat (40) @(negedge clock);
        rst = 1'b1;
        @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        check("oeRst", 16'(u_sacr_link_if.resultOe), 16'h0000);
        push(16'h0001);
        run(1'b0);
        pop(16'h8001);
    endtask

    task automatic finish_test();
        $display("Checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        clock         = 1'b0;
        rst           = 1'b1;
        sampleValid   = 1'b0;
        sampleData    = 16'h0000;
        startReq      = 1'b0;
        shutdownAfter = 1'b0;
        resetReq      = 1'b0;
        resultReady   = 1'b0;
        n_fail        = 0;
        n_tests       = 0;
        cycles        = 0;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        t_modes();
        t_fifo();
        t_reset();
        finish_test();
    end
endmodule
`default_nettype wire
